// ==== ipsf_core_model.sv ====
// Core-side model: vectors to a source on command and signals returns
`timescale 1ns/100ps
module ipsf_core_model
  import ipsf_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Device side
  input  wire logic [7:0] irq_req,
  input  wire logic       preempt_ok,
  output logic      [7:0] vector_ack,
  output logic            return_evt,
  // Bench commands
  input  wire logic       vec_go,
  input  wire logic [2:0] vec_src,
  input  wire logic [3:0] vec_lat,
  input  wire logic       ret_go,
  output logic            vec_done,
  output logic            vec_took
);
  logic [3:0] wait_reg;
  logic       busy_reg;
  // Wait the commanded latency, then vector only when allowed
  always_ff @(posedge clk) begin
    vector_ack <= 8'h00;
    vec_done <= 1'b0;
    if (rst) begin
      busy_reg <= 1'b0;
      wait_reg <= 4'h0;
      vec_took <= 1'b0;
    end else if (vec_go && !busy_reg) begin
      busy_reg <= 1'b1;
      wait_reg <= vec_lat;
    end else if (busy_reg && wait_reg != 4'h0) begin
      wait_reg <= wait_reg - 4'h1;
    end else if (busy_reg) begin
      busy_reg <= 1'b0;
      vec_done <= 1'b1;
      vec_took <= irq_req[vec_src] & preempt_ok;
      if (irq_req[vec_src] && preempt_ok) begin
        vector_ack[vec_src] <= 1'b1;
      end
    end
  end
  // One-cycle routine return
  always_ff @(posedge clk) begin
    return_evt <= ret_go & !rst;
  end
endmodule // ipsf_core_model

// ==== ipsf_params.svh ====
// Register offsets, field positions and reset values of the flag block
// What this block does
// - Sources 0..5: priority level is high bit and low bit, 0..3; sources 6,7 have low bit 0
// - Low-priority register holds six source priority bits, bits 7..6 unused
// - Timer 1 overflow flag set on overflow, cleared on vector or software
// - Timer 0 overflow flag set on overflow, cleared on vector or software
// - Timer 0 and 1 run bits: 0 stops, 1 runs
// - External request flags set on detect, cleared by software or, in edge mode only, on vector
// - Trigger select 0 gives low level, 1 gives falling edge
// - Timer 2 overflow flag set on overflow unless serial clock uses timer 2
// - Pin fall with enable sets timer 2 external flag unless serial clock uses timer 2; no request in up/down
// - Modes 1 and 3: clock selects route timer 2 or timer 1 overflows
// - Pin fall triggers capture/reload only if enabled and not clocking serial
// - Timer 2 counts only while its run bit is 1
// - Counter select 0 counts clocks, 1 counts external falling edges
// - Capture select 0 reloads on overflow or pin, 1 captures on pin
// - With access select set, serial bit 7 reads framing error flag
// - Two mode bits choose shift, 8-bit, fixed 9-bit or variable 9-bit
// - Modes 2,3 with filter: receive flag needs ninth bit 1 and address match
// - Mode 1 with filter: receive flag needs valid stop and address match
// - Receiver accepts data only while receive enable is 1
// - Modes 2,3: ninth bits go out from and in to the ninth-bit fields
// - Transmit flag set at frame end, cleared only by software
// - Receive flag set at stop sampling, never cleared by hardware
// - Serial request is receive OR transmit; timer 2 is overflow OR external outside up/down
// - Software writes set or clear flags exactly like hardware
// - Only a strictly higher level preempts; level 3 never preempted
`ifndef IPSF_PARAMS_SVH
`define IPSF_PARAMS_SVH
`define IPSF_ADR_TMR01   8'h88
`define IPSF_ADR_SERIAL  8'h98
`define IPSF_ADR_PRIO_HI 8'hb7
`define IPSF_ADR_PRIO_LO 8'hb8
`define IPSF_ADR_TMR2    8'hc8
`define IPSF_ADR_AUX     8'hcc
`define IPSF_ADR_STATUS  8'hd0
`define IPSF_RST_BYTE    8'h00
`define IPSF_B_T1_FLAG   7
`define IPSF_B_T1_RUN    6
`define IPSF_B_T0_FLAG   5
`define IPSF_B_T0_RUN    4
`define IPSF_B_X1_FLAG   3
`define IPSF_B_X1_TRIG   2
`define IPSF_B_X0_FLAG   1
`define IPSF_B_X0_TRIG   0
`define IPSF_B_T2_OVF    7
`define IPSF_B_T2_EXT    6
`define IPSF_B_RX_CLK2   5
`define IPSF_B_TX_CLK2   4
`define IPSF_B_T2_PINEN  3
`define IPSF_B_T2_RUN    2
`define IPSF_B_T2_CNT    1
`define IPSF_B_T2_CAP    0
`define IPSF_B_SM_HI     7
`define IPSF_B_SM_LO     6
`define IPSF_B_FILTER    5
`define IPSF_B_RX_EN     4
`define IPSF_B_TX9       3
`define IPSF_B_RX9       2
`define IPSF_B_TX_DONE   1
`define IPSF_B_RX_DONE   0
`define IPSF_B_FE_SEL    0
`define IPSF_B_BAUD2     1
`define IPSF_B_UPDOWN    2
`define IPSF_PRIO_LO_MASK 8'h3f
`endif

// ==== ipsf_pkg.sv ====
// Types shared by the flag block
package ipsf_pkg;
  typedef enum logic [1:0] {
    IPSF_BUS_IDLE = 2'b00,
    IPSF_BUS_ACK  = 2'b01
  } ipsf_bus_t;
  typedef enum logic [1:0] {
    IPSF_SM_SHIFT = 2'b00,
    IPSF_SM_UART8 = 2'b01,
    IPSF_SM_FIX9  = 2'b10,
    IPSF_SM_VAR9  = 2'b11
  } ipsf_smode_t;
  typedef logic [1:0] ipsf_level_t;
endpackage

// ==== ipsf_top.sv ====
// Interrupt priority and source flag registers with a Wishbone slave
`timescale 1ns/100ps
`include "ipsf_params.svh"
module ipsf_top
  import ipsf_pkg::*;
#(
  parameter int NSRC = 8
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Wishbone slave
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [7:0]       wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  // Pins, sampled once per clock
  input  wire logic             ext_irq_pin_zero_n,
  input  wire logic             ext_irq_pin_one_n,
  input  wire logic             timer2_capture_pin_n,
  // Datapath events
  input  wire logic             timer0_ovf_evt,
  input  wire logic             timer1_ovf_evt,
  input  wire logic             timer2_ovf_evt,
  input  wire logic             rx_stop_evt,
  input  wire logic             rx_stop_valid,
  input  wire logic             rx_ninth_in,
  input  wire logic             rx_addr_match,
  input  wire logic             tx_done_evt,
  // Core vectoring: one-hot acknowledge and return
  input  wire logic [NSRC-1:0]  vector_ack,
  input  wire logic             return_evt,
  // Requests and priorities to the core
  output logic      [NSRC-1:0]  irq_req,
  output logic      [2*NSRC-1:0] irq_level,
  output logic                  preempt_ok,
  // Controls to the datapaths
  output logic                  timer0_run,
  output logic                  timer1_run,
  output logic                  timer2_count_en,
  output logic                  timer2_count_ext,
  output logic                  timer2_reload_evt,
  output logic                  timer2_capture_evt,
  output logic                  serial_rx_clk_t2,
  output logic                  serial_tx_clk_t2,
  output logic      [1:0]       serial_mode,
  output logic                  baud_doubler,
  output logic                  rx_enable,
  output logic                  tx_ninth_bit
);
  logic [7:0] tmr01_reg, tmr2_reg, serial_reg, prio_lo_reg, prio_hi_reg;
  logic [7:0] aux_reg;
  logic       framing_error_flag;
  logic       pin0_q, pin1_q, pin2ex_q;
  logic [3:0] act_reg;              // In-progress levels, one bit per level
  logic [3:0] act_next;
  ipsf_bus_t  bus_reg;
  logic       wr, rd, fe_sel, t2_ser;
  logic       fall0, fall1, fall2ex, t2_trig;
  logic [7:0] wdat;
  logic [1:0] top_active;
  logic [1:0] top_pend;
  logic       any_pend;
  logic [NSRC-1:0] raw_req;

  assign wdat   = wb_dat_i[7:0];
  assign wr     = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && !wb_ack_o;
  assign rd     = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign fe_sel = aux_reg[`IPSF_B_FE_SEL];
  // Serial port counts as clocked by timer 2 whenever either clock select is set, in any mode
  assign t2_ser = (tmr2_reg[`IPSF_B_RX_CLK2] || tmr2_reg[`IPSF_B_TX_CLK2]);
  assign fall0   = pin0_q && !ext_irq_pin_zero_n;
  assign fall1   = pin1_q && !ext_irq_pin_one_n;
  assign fall2ex = pin2ex_q && !timer2_capture_pin_n;
  assign t2_trig = fall2ex && tmr2_reg[`IPSF_B_T2_PINEN] && !t2_ser;

  // Pin history for falling-edge detection
  always_ff @(posedge clk) begin
    if (rst) begin
      pin0_q   <= 1'b1;
      pin1_q   <= 1'b1;
      pin2ex_q <= 1'b1;
    end else begin
      pin0_q   <= ext_irq_pin_zero_n;
      pin1_q   <= ext_irq_pin_one_n;
      pin2ex_q <= timer2_capture_pin_n;
    end
  end

  // Bus handshake: ack one cycle after the request
  always_ff @(posedge clk) begin
    if (rst) begin
      bus_reg  <= IPSF_BUS_IDLE;
      wb_ack_o <= 1'b0;
    end else begin
      case (bus_reg)
        IPSF_BUS_IDLE: begin
          if (wb_cyc_i && wb_stb_i) begin
            bus_reg  <= IPSF_BUS_ACK;
            wb_ack_o <= 1'b1;
          end
        end
        IPSF_BUS_ACK: begin
          bus_reg  <= IPSF_BUS_IDLE;
          wb_ack_o <= 1'b0;
        end
        default: begin
          bus_reg  <= IPSF_BUS_IDLE;
          wb_ack_o <= 1'b0;
        end
      endcase
    end
  end

  // Read data; unmapped offsets read zero
  always_ff @(posedge clk) begin
    if (rst) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (rd) begin
      case (wb_adr_i)
        `IPSF_ADR_TMR01:   wb_dat_o <= {24'h00_0000, tmr01_reg};
        `IPSF_ADR_TMR2:    wb_dat_o <= {24'h00_0000, tmr2_reg};
        `IPSF_ADR_SERIAL:  wb_dat_o <= {24'h00_0000,
                             fe_sel ? framing_error_flag
                                    : serial_reg[`IPSF_B_SM_HI],
                             serial_reg[6:0]};
        `IPSF_ADR_PRIO_LO: wb_dat_o <= {24'h00_0000,
                             prio_lo_reg & `IPSF_PRIO_LO_MASK};
        `IPSF_ADR_PRIO_HI: wb_dat_o <= {24'h00_0000, prio_hi_reg};
        `IPSF_ADR_AUX:     wb_dat_o <= {24'h00_0000, aux_reg};
        `IPSF_ADR_STATUS:  wb_dat_o <= {28'h000_0000, act_reg};
        default:           wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // Priority registers and auxiliary control
  always_ff @(posedge clk) begin
    if (rst) begin
      prio_lo_reg <= `IPSF_RST_BYTE;
      prio_hi_reg <= `IPSF_RST_BYTE;
      aux_reg     <= `IPSF_RST_BYTE;
    end else if (wr) begin
      if (wb_adr_i == `IPSF_ADR_PRIO_LO)
        prio_lo_reg <= wdat & `IPSF_PRIO_LO_MASK;
      if (wb_adr_i == `IPSF_ADR_PRIO_HI)
        prio_hi_reg <= wdat;
      if (wb_adr_i == `IPSF_ADR_AUX)
        aux_reg <= {5'b0_0000, wdat[2:0]};
    end
  end

  // Timer 0/1 control: hardware set beats software clear
  always_ff @(posedge clk) begin
    if (rst) begin
      tmr01_reg <= `IPSF_RST_BYTE;
    end else begin
      logic [7:0] v;
      v = tmr01_reg;
      if (wr && wb_adr_i == `IPSF_ADR_TMR01)
        v = wdat;
      // Vectoring clears overflow flags; edge-mode external flags only
      if (vector_ack[3]) v[`IPSF_B_T1_FLAG] = 1'b0;
      if (vector_ack[1]) v[`IPSF_B_T0_FLAG] = 1'b0;
      if (vector_ack[2] && tmr01_reg[`IPSF_B_X1_TRIG])
        v[`IPSF_B_X1_FLAG] = 1'b0;
      if (vector_ack[0] && tmr01_reg[`IPSF_B_X0_TRIG])
        v[`IPSF_B_X0_FLAG] = 1'b0;
      if (timer1_ovf_evt) v[`IPSF_B_T1_FLAG] = 1'b1;
      if (timer0_ovf_evt) v[`IPSF_B_T0_FLAG] = 1'b1;
      // Level mode sets the flag while the pin is low; edge mode latches a fall
      if (tmr01_reg[`IPSF_B_X1_TRIG] ? fall1 : !ext_irq_pin_one_n)
        v[`IPSF_B_X1_FLAG] = 1'b1;
      if (tmr01_reg[`IPSF_B_X0_TRIG] ? fall0 : !ext_irq_pin_zero_n)
        v[`IPSF_B_X0_FLAG] = 1'b1;
      tmr01_reg <= v;
    end
  end

  // Timer 2 control; its flags are cleared only by software
  always_ff @(posedge clk) begin
    if (rst) begin
      tmr2_reg <= `IPSF_RST_BYTE;
    end else begin
      logic [7:0] v;
      v = tmr2_reg;
      if (wr && wb_adr_i == `IPSF_ADR_TMR2)
        v = wdat;
      if (timer2_ovf_evt && !t2_ser)
        v[`IPSF_B_T2_OVF] = 1'b1;
      if (t2_trig)
        v[`IPSF_B_T2_EXT] = 1'b1;
      tmr2_reg <= v;
    end
  end

  // Serial control and framing error
  always_ff @(posedge clk) begin
    if (rst) begin
      serial_reg         <= `IPSF_RST_BYTE;
      framing_error_flag <= 1'b0;
    end else begin
      logic [7:0] v;
      logic       fe;
      logic       ok;
      v  = serial_reg;
      fe = framing_error_flag;
      if (wr && wb_adr_i == `IPSF_ADR_SERIAL) begin
        v = wdat;
        if (fe_sel) begin
          v[`IPSF_B_SM_HI] = serial_reg[`IPSF_B_SM_HI];
          fe = wdat[7];
        end
      end
      if (tx_done_evt) v[`IPSF_B_TX_DONE] = 1'b1;
      if (rx_stop_evt && serial_reg[`IPSF_B_RX_EN]) begin
        if (!rx_stop_valid) fe = 1'b1;
        case (ipsf_smode_t'(serial_reg[7:6]))
          IPSF_SM_FIX9, IPSF_SM_VAR9: begin
            ok = !serial_reg[`IPSF_B_FILTER] ||
                 (rx_ninth_in && rx_addr_match);
            if (ok) v[`IPSF_B_RX9] = rx_ninth_in;
          end
          IPSF_SM_UART8:
            ok = !serial_reg[`IPSF_B_FILTER] ||
                 (rx_stop_valid && rx_addr_match);
          default: ok = 1'b1;
        endcase
        if (ok) v[`IPSF_B_RX_DONE] = 1'b1;
      end
      serial_reg         <= v;
      framing_error_flag <= fe;
    end
  end

  // Level-ordered in-progress stack for nesting
  always_comb begin
    act_next = act_reg;
    if (return_evt) begin
      if (act_reg[3])      act_next[3] = 1'b0;
      else if (act_reg[2]) act_next[2] = 1'b0;
      else if (act_reg[1]) act_next[1] = 1'b0;
      else                 act_next[0] = 1'b0;
    end
    for (int i = 0; i < NSRC; i++)
      if (vector_ack[i]) act_next[irq_level[2*i +: 2]] = 1'b1;
  end

  always_ff @(posedge clk) begin
    if (rst) act_reg <= 4'h0;
    else     act_reg <= act_next;
  end

  // Highest level now in progress and highest pending level
  always_comb begin
    top_active = 2'd0;
    top_pend   = 2'd0;
    any_pend   = 1'b0;
    for (int l = 0; l < 4; l++)
      if (act_reg[l]) top_active = 2'(l);
    for (int i = 0; i < NSRC; i++)
      if (raw_req[i]) begin
        any_pend = 1'b1;
        if (irq_level[2*i +: 2] > top_pend) top_pend = irq_level[2*i +: 2];
      end
  end

  // Raw request vector in polling order
  always_comb begin
    raw_req    = '0;
    raw_req[0] = tmr01_reg[`IPSF_B_X0_FLAG];
    raw_req[1] = tmr01_reg[`IPSF_B_T0_FLAG];
    raw_req[2] = tmr01_reg[`IPSF_B_X1_FLAG];
    raw_req[3] = tmr01_reg[`IPSF_B_T1_FLAG];
    raw_req[4] = serial_reg[`IPSF_B_RX_DONE] ||
                 serial_reg[`IPSF_B_TX_DONE];
    raw_req[5] = tmr2_reg[`IPSF_B_T2_OVF] ||
                 (tmr2_reg[`IPSF_B_T2_EXT] &&
                  !aux_reg[`IPSF_B_UPDOWN]);
  end

  // Registered outputs to core and datapaths
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_req    <= '0;
      irq_level  <= '0;
      preempt_ok <= 1'b0;
    end else begin
      irq_req <= raw_req;
      for (int i = 0; i < NSRC; i++)
        irq_level[2*i +: 2] <= {prio_hi_reg[i],
                                (i < 6) ? prio_lo_reg[i] : 1'b0};
      preempt_ok <= any_pend &&
                    (act_reg == 4'h0 || top_pend > top_active);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      timer0_run         <= 1'b0;
      timer1_run         <= 1'b0;
      timer2_count_en    <= 1'b0;
      timer2_count_ext   <= 1'b0;
      timer2_reload_evt  <= 1'b0;
      timer2_capture_evt <= 1'b0;
      serial_rx_clk_t2   <= 1'b0;
      serial_tx_clk_t2   <= 1'b0;
      serial_mode        <= 2'b00;
      baud_doubler       <= 1'b0;
      rx_enable          <= 1'b0;
      tx_ninth_bit       <= 1'b0;
    end else begin
      timer0_run       <= tmr01_reg[`IPSF_B_T0_RUN];
      timer1_run       <= tmr01_reg[`IPSF_B_T1_RUN];
      timer2_count_en  <= tmr2_reg[`IPSF_B_T2_RUN];
      timer2_count_ext <= tmr2_reg[`IPSF_B_T2_CNT];
      timer2_reload_evt  <= !tmr2_reg[`IPSF_B_T2_CAP] &&
                            (t2_trig || (timer2_ovf_evt && !t2_ser));
      timer2_capture_evt <= tmr2_reg[`IPSF_B_T2_CAP] && t2_trig;
      serial_rx_clk_t2 <= tmr2_reg[`IPSF_B_RX_CLK2] &&
                          serial_reg[`IPSF_B_SM_LO];
      serial_tx_clk_t2 <= tmr2_reg[`IPSF_B_TX_CLK2] &&
                          serial_reg[`IPSF_B_SM_LO];
      serial_mode      <= serial_reg[7:6];
      baud_doubler     <= aux_reg[`IPSF_B_BAUD2];
      rx_enable        <= serial_reg[`IPSF_B_RX_EN];
      tx_ninth_bit     <= serial_reg[`IPSF_B_TX9];
    end
  end

  // Timer 0 overflow flag is set the cycle after the event
  chk_t0_flag_set: assert property (@(posedge clk) disable iff (rst)
    timer0_ovf_evt |=> tmr01_reg[`IPSF_B_T0_FLAG])
    else $error("timer 0 flag not set");
  chk_t1_flag_set: assert property (@(posedge clk) disable iff (rst)
    timer1_ovf_evt |=> tmr01_reg[`IPSF_B_T1_FLAG])
    else $error("timer 1 flag not set");
  // A clear overflow flag stays clear while timer 2 clocks the serial port and no bus write occurs
  chk_t2_ovf_block: assert property (@(posedge clk) disable iff (rst)
    (t2_ser && !tmr2_reg[`IPSF_B_T2_OVF] && !wr) |=>
    !tmr2_reg[`IPSF_B_T2_OVF])
    else $error("timer 2 flag set while clocking serial");
  // A seen fall in edge mode always latches the external 0 flag
  chk_x0_edge_set: assert property (@(posedge clk) disable iff (rst)
    (tmr01_reg[`IPSF_B_X0_TRIG] && fall0) |=>
    tmr01_reg[`IPSF_B_X0_FLAG])
    else $error("edge flag 0 not set");
  chk_rx_needs_en: assert property (@(posedge clk) disable iff (rst)
    (!serial_reg[`IPSF_B_RX_DONE] && !serial_reg[`IPSF_B_RX_EN] && !wr)
    |=> !serial_reg[`IPSF_B_RX_DONE])
    else $error("receive flag set with receiver off");
  chk_serial_req_or: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> irq_req[4] == $past(serial_reg[1] || serial_reg[0]))
    else $error("serial request not or of flags");
  chk_run_follow: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> timer2_count_en == $past(tmr2_reg[`IPSF_B_T2_RUN]))
    else $error("timer 2 run not followed");
  chk_tx_flag_set: assert property (@(posedge clk) disable iff (rst)
    tx_done_evt |=> serial_reg[`IPSF_B_TX_DONE])
    else $error("transmit flag not set");
  chk_top_no_preempt: assert property (@(posedge clk) disable iff (rst)
    act_reg[3] |=> !preempt_ok)
    else $error("level 3 routine preempted");
  chk_ack_one: assert property (@(posedge clk) disable iff (rst)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");
endmodule // ipsf_top

// ==== tb_top.sv ====
// Self-checking bench for the priority and source flag block
`timescale 1ns/100ps
`include "ipsf_params.svh"
module tb_top;
  import ipsf_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [3:0]  sel = 4'h0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic        ack;
  logic [2:0]  pin_n = 3'b111;
  logic [4:0]  ev = 5'h00;
  logic [2:0]  rxq = 3'b100;
  logic [7:0]  vack, req, q;
  logic [15:0] lvl;
  logic [8:0]  ctl;
  logic [1:0]  smode, t2ev;
  logic        rev, pok, vdone, vtook;
  logic        vgo = 1'b0;
  logic        rgo = 1'b0;
  logic [2:0]  vsrc = 3'h0;
  logic [3:0]  vlat = 4'h0;
  logic [3:0]  cap_n = 4'h0;
  logic [3:0]  rel_n = 4'h0;
  logic [31:0] lf = 32'h0000_fa57;
  logic [7:0]  ra [5] = '{8'h88, 8'h98, 8'hb8, 8'hc8, 8'h10};
  int          fails = 0;
  int          cmp_count = 0;
  // Clock and timer 2 event counters
  always #5 clk = ~clk;
  always @(posedge clk) begin
    if (rst) begin
      cap_n <= 4'h0;
      rel_n <= 4'h0;
    end else begin
      cap_n <= cap_n + {3'h0, t2ev[0]};
      rel_n <= rel_n + {3'h0, t2ev[1]};
    end
  end
  // Design and core model
  ipsf_top uut (
    .clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .ext_irq_pin_zero_n(pin_n[0]),
    .ext_irq_pin_one_n(pin_n[1]), .timer2_capture_pin_n(pin_n[2]),
    .timer0_ovf_evt(ev[0]), .timer1_ovf_evt(ev[1]), .timer2_ovf_evt(ev[2]),
    .rx_stop_evt(ev[3]), .tx_done_evt(ev[4]), .rx_stop_valid(rxq[2]),
    .rx_ninth_in(rxq[1]), .rx_addr_match(rxq[0]), .vector_ack(vack),
    .return_evt(rev), .irq_req(req), .irq_level(lvl), .preempt_ok(pok),
    .timer0_run(ctl[0]), .timer1_run(ctl[1]), .timer2_count_en(ctl[2]),
    .timer2_count_ext(ctl[3]), .serial_rx_clk_t2(ctl[4]),
    .serial_tx_clk_t2(ctl[5]), .baud_doubler(ctl[6]), .rx_enable(ctl[7]),
    .tx_ninth_bit(ctl[8]), .serial_mode(smode),
    .timer2_capture_evt(t2ev[0]), .timer2_reload_evt(t2ev[1]));
  ipsf_core_model core (
    .clk(clk), .rst(rst), .irq_req(req), .preempt_ok(pok),
    .vector_ack(vack), .return_evt(rev), .vec_go(vgo), .vec_src(vsrc),
    .vec_lat(vlat), .ret_go(rgo), .vec_done(vdone), .vec_took(vtook));
  // Random source and expected levels
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [15:0] exp_lvl(input logic [7:0] pl, ph);
    logic [15:0] v;
    for (int i = 0; i < 8; i++) v[2*i +: 2] = {ph[i], (i < 6) & pl[i]};
    return v;
  endfunction
  // Verdict and run end
  task automatic end_sim(input int t);
    fails += t;
    $display("fails=%0d cmp_count=%0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t port got %h exp %h", $time, got, exp);
    end
  endtask
  // One classic Wishbone cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, d);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'h1;
    adr <= a;
    wdat <= {24'h00_0000, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    sel <= 4'h0;
    if (n >= 20) end_sim(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    wb(1'b0, a, 8'h00);
    cmp_count++;
    if (q !== exp) begin
      fails++;
      $display("BAD t=%0t reg %h got %h exp %h", $time, a, q, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic evp(input logic [4:0] e, input logic [2:0] r = 3'b100);
    @(posedge clk);
    ev <= e;
    rxq <= r;
    @(posedge clk);
    ev <= 5'h00;
    wt(2);
  endtask
  task automatic pf(input int k);
    @(posedge clk);
    pin_n[k] <= 1'b1;
    @(posedge clk);
    pin_n[k] <= 1'b0;
    wt(3);
  endtask
  // Vector through the core model, optionally return afterwards
  task automatic vec(input logic [2:0] s, input logic t, r);
    int n;
    lf = lfsr(lf);
    @(posedge clk);
    vgo <= 1'b1;
    vsrc <= s;
    vlat <= lf[3:0];
    @(posedge clk);
    vgo <= 1'b0;
    n = 0;
    while (vdone !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    if (n >= 40) end_sim(1);
    chk(vtook, t);
    rgo <= r;
    @(posedge clk);
    rgo <= 1'b0;
    wt(2);
  endtask
  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    foreach (ra[i]) rd(ra[i], 8'h00);
    wb(1'b1, `IPSF_ADR_PRIO_LO, 8'hff);
    rd(`IPSF_ADR_PRIO_LO, `IPSF_PRIO_LO_MASK);
    repeat (6) begin
      lf = lfsr(lf);
      wb(1'b1, `IPSF_ADR_PRIO_LO, lf[7:0]);
      wb(1'b1, `IPSF_ADR_PRIO_HI, lf[15:8]);
      wt(2);
      chk(lvl, exp_lvl(lf[7:0], lf[15:8]));
    end
    wb(1'b1, `IPSF_ADR_TMR01, 8'h50);
    wt(2);
    chk(ctl[1:0], 2'b11);
    // Timer 0 at level 3 blocks timer 1 until return
    wb(1'b1, `IPSF_ADR_PRIO_LO, 8'h02);
    wb(1'b1, `IPSF_ADR_PRIO_HI, 8'h02);
    evp(5'h03);
    chk({pok, req}, 9'h10a);
    rd(`IPSF_ADR_TMR01, 8'hf0);
    vec(3'd1, 1'b1, 1'b0);
    chk({pok, req}, 9'h008);
    vec(3'd3, 1'b0, 1'b1);
    vec(3'd3, 1'b1, 1'b1);
    rd(`IPSF_ADR_TMR01, 8'h50);
    // Software set, then a clear racing a hardware set
    wb(1'b1, `IPSF_ADR_TMR01, 8'h20);
    wt(2);
    chk(req, 16'h0002);
    fork
      wb(1'b1, `IPSF_ADR_TMR01, 8'h00);
      begin
        @(posedge clk);
        ev <= 5'h02;
        @(posedge clk);
        ev <= 5'h00;
      end
    join
    rd(`IPSF_ADR_TMR01, 8'h80);
    // External pins in edge mode, then level mode
    wb(1'b1, `IPSF_ADR_TMR01, 8'h05);
    pf(0);
    pf(1);
    rd(`IPSF_ADR_TMR01, 8'h0f);
    wb(1'b1, `IPSF_ADR_TMR01, 8'h0d);
    rd(`IPSF_ADR_TMR01, 8'h0d);
    vec(3'd2, 1'b1, 1'b1);
    rd(`IPSF_ADR_TMR01, 8'h05);
    wb(1'b1, `IPSF_ADR_TMR01, 8'h00);
    rd(`IPSF_ADR_TMR01, 8'h0a);
    vec(3'd0, 1'b1, 1'b1);
    rd(`IPSF_ADR_TMR01, 8'h0a);
    @(posedge clk);
    pin_n[1:0] <= 2'b11;
    wb(1'b1, `IPSF_ADR_TMR01, 8'h00);
    rd(`IPSF_ADR_TMR01, 8'h00);
    // Timer 2 overflow, clock routing, capture and reload
    evp(5'h04);
    chk(req[5], 1'b1);
    vec(3'd5, 1'b1, 1'b1);
    rd(`IPSF_ADR_TMR2, 8'h80);
    wb(1'b1, `IPSF_ADR_TMR2, 8'h20);
    evp(5'h04);
    rd(`IPSF_ADR_TMR2, 8'h20);
    chk(ctl[5:4], 2'b00);
    wb(1'b1, `IPSF_ADR_SERIAL, 8'h40);
    wt(2);
    chk(ctl[5:4], 2'b01);
    wb(1'b1, `IPSF_ADR_TMR2, 8'h0f);
    pf(2);
    rd(`IPSF_ADR_TMR2, 8'h4f);
    chk({cap_n, rel_n, ctl[3:2]}, {4'd1, 4'd1, 2'b11});
    wb(1'b1, `IPSF_ADR_AUX, 8'h06);
    wt(2);
    chk({ctl[6], req[5]}, 2'b10);
    wb(1'b1, `IPSF_ADR_AUX, 8'h00);
    wb(1'b1, `IPSF_ADR_TMR2, 8'h08);
    pf(2);
    evp(5'h04);
    chk({cap_n, rel_n, req[5]}, {4'd1, 4'd3, 1'b1});
    wb(1'b1, `IPSF_ADR_TMR2, 8'h18);
    pf(2);
    rd(`IPSF_ADR_TMR2, 8'h18);
    chk({rel_n, ctl[2]}, {4'd3, 1'b0});
    // Serial flags, filter and ninth bits
    wb(1'b1, `IPSF_ADR_SERIAL, 8'h10);
    evp(5'h08);
    chk(req[4], 1'b1);
    vec(3'd4, 1'b1, 1'b1);
    rd(`IPSF_ADR_SERIAL, 8'h11);
    wb(1'b1, `IPSF_ADR_SERIAL, 8'h00);
    evp(5'h18);
    rd(`IPSF_ADR_SERIAL, 8'h02);
    wb(1'b1, `IPSF_ADR_SERIAL, 8'hb0);
    evp(5'h08, 3'b101);
    rd(`IPSF_ADR_SERIAL, 8'hb0);
    evp(5'h08, 3'b111);
    rd(`IPSF_ADR_SERIAL, 8'hb5);
    wb(1'b1, `IPSF_ADR_SERIAL, 8'h78);
    evp(5'h08, 3'b001);
    rd(`IPSF_ADR_SERIAL, 8'h78);
    chk(ctl[8:7], 2'b11);
    wb(1'b1, `IPSF_ADR_AUX, 8'h01);
    rd(`IPSF_ADR_SERIAL, 8'hf8);
    wb(1'b1, `IPSF_ADR_SERIAL, 8'h78);
    wb(1'b1, `IPSF_ADR_AUX, 8'h00);
    rd(`IPSF_ADR_SERIAL, 8'h78);
    for (int m = 0; m < 4; m++) begin
      wb(1'b1, `IPSF_ADR_SERIAL, {m[1:0], 6'h00});
      wt(2);
      chk(smode, m[1:0]);
    end
    end_sim(0);
  end
endmodule // tb_top
